// File: verification/clock_receiver.sv
// Receiver model that measures high and low run lengths of the output clock
`timescale 1ns/1ps
`default_nettype none
module clock_receiver (
  input wire logic clock,
  input wire logic rst,
  input wire logic true_pad,
  output logic per_done,
  output logic [35:0] per_high,
  output logic [35:0] per_low
);
  logic prev_r; // Pad level seen last edge
  logic [35:0] run_r; // Cycles at the current level
  // Count source-clock periods per level; a period ends on a rising pad
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      run_r <= 36'h0_0000_0000;
      per_done <= 1'b0;
      per_high <= 36'h0_0000_0000;
      per_low <= 36'h0_0000_0000;
    end else begin
      prev_r <= true_pad;
      per_done <= 1'b0;
      if (true_pad != prev_r) begin
        run_r <= 36'h0_0000_0001; // Whole periods only
        if (!true_pad) begin
          per_high <= run_r;
        end else begin
          per_low <= run_r;
          per_done <= 1'b1;
        end
      end else begin
        run_r <= run_r + 36'h0_0000_0001;
      end
    end
  end
endmodule // clock_receiver
`default_nettype wire

// File: verification/output_coarse_phase_adjust_test.sv
// Self-checking bench for the output coarse phase adjuster
`timescale 1ns/1ps
`default_nettype none
module output_coarse_phase_adjust_test
  import coarse_phase_pkg::*;
;
  logic clock = 1'b0; // Source clock
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic true_pad, complement_pad, diff_mode;
  logic [1:0] swing_select, impedance_select;
  logic [2:0] pad_supply_select, common_mode_select;
  logic per_done; // One period measured
  logic [35:0] per_high, per_low;
  int fails = 0;
  int checks_done = 0;
  output_coarse_phase_adjust output_coarse_phase_adjust_inst (.clock(clock), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .true_pad(true_pad),
    .complement_pad(complement_pad), .diff_mode(diff_mode), .swing_select(swing_select),
    .impedance_select(impedance_select), .pad_supply_select(pad_supply_select),
    .common_mode_select(common_mode_select));
  clock_receiver clock_receiver_inst (.clock(clock), .rst(rst), .true_pad(true_pad),
    .per_done(per_done), .per_high(per_high), .per_low(per_low));
  // 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic give_verdict;
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check({4'h0, rdata}, {4'h0, exp});
  endtask
  // Bounded wait for the receiver to finish one period
  task automatic get_period(output logic [35:0] h, output logic [35:0] l);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (per_done !== 1'b1 && n < 300);
    if (n >= 300) begin
      fails++;
      $display("ERROR %0t: no output period", $time);
      give_verdict();
    end
    h = per_high;
    l = per_low;
  endtask
  // One shifted period expected among three, the rest nominal
  task automatic expect_shift(input logic [33:0] v, input logic [35:0] h, input logic [35:0] l,
                              input logic [35:0] nh, input logic [35:0] nl);
    logic [35:0] ph, pl;
    int hits;
    hits = 0;
    get_period(ph, pl);
    wr_reg(REG_ADJ_LO, v[31:0]);
    wr_reg(REG_ADJ_HI, {30'h0000_0000, v[33:32]});
    repeat (3) begin
      get_period(ph, pl);
      if (ph === h && pl === l) hits++;
      else begin
        check(ph, nh);
        check(pl, nl);
      end
    end
    check(36'(hits), 36'h0_0000_0001);
  endtask
  task automatic s_reset;
    rd_reg(REG_DIV, DIV_RST);
    rd_reg(REG_HIGH, HIGH_RST);
    rd_reg(REG_BUF, {20'h0_0000, BUF_RST});
    rd_reg(3'h7, 32'h0000_0000);
  endtask
  // Balanced duty, then grow, shrink, clamp; successive requests
  task automatic s_balanced;
    wr_reg(REG_DIV, 32'h0000_000A);
    expect_shift(34'h0_0000_0004, 36'd7, 36'd7, 36'd5, 36'd5);
    expect_shift(34'h3_FFFF_FFFC, 36'd3, 36'd3, 36'd5, 36'd5);
    expect_shift(34'h3_FFFF_FFEC, 36'd2, 36'd2, 36'd5, 36'd5);
    rd_reg(REG_ADJ_LO, 32'hFFFF_FFEC);
    rd_reg(REG_ADJ_HI, 32'h0000_0003);
  endtask
  // Pulse mode puts the whole shift on the low portion
  task automatic s_pulse;
    wr_reg(REG_HIGH, 32'h0000_0003);
    expect_shift(34'h0_0000_0005, 36'd3, 36'd12, 36'd3, 36'd7);
    wr_reg(REG_HIGH, 32'h0000_0000);
  endtask
  // Single-ended codes, with and without complement inversion
  task automatic s_buffer;
    for (int c = 0; c < 16; c++) begin
      wr_reg(REG_BUF, 32'((c << 2) | ((c & 1) << 1) | ((c & 7) << 6) | ((c & 7) << 9)));
      repeat (3) @(negedge clock);
      check(36'(diff_mode), 36'h0_0000_0000);
      check(36'(swing_select), 36'(c & 3));
      check(36'(impedance_select), 36'((c >> 2) & 3));
      check(36'(pad_supply_select), 36'(c & 7));
      check(36'(common_mode_select), 36'(c & 7));
      repeat (6) begin
        @(negedge clock);
        check(36'(complement_pad ^ true_pad), 36'(c & 1));
      end
    end
    wr_reg(REG_BUF, 32'h0000_0001);
    repeat (3) @(negedge clock);
    check(36'(diff_mode), 36'h0_0000_0001);
    check(36'(complement_pad ^ true_pad), 36'h0_0000_0001);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    s_reset();
    s_balanced();
    s_pulse();
    s_buffer();
    give_verdict();
  end
endmodule // output_coarse_phase_adjust_test
`default_nettype wire

// File: verilog/coarse_phase_pkg.sv
// Constants and types for the per-output coarse phase adjuster
package coarse_phase_pkg;
  localparam int DIV_W = 32;               // Divider and width fields
  localparam int ADJ_W = 34;               // Signed shift, -2^33 to 2^33-1
  localparam int CNT_W = 35;               // Phase counter, holds extended halves
  localparam logic [31:0] MIN_HALF = 32'h0000_0002; // Least half length
  localparam logic [31:0] DIV_RST = 32'h0000_000A;  // Divider reset value
  localparam logic [31:0] HIGH_RST = 32'h0000_0000; // Balanced at reset
  localparam logic [2:0] REG_DIV = 3'h0;   // Divider value
  localparam logic [2:0] REG_HIGH = 3'h1;  // Pulse high width
  localparam logic [2:0] REG_ADJ_LO = 3'h2; // Shift low 32 bits
  localparam logic [2:0] REG_ADJ_HI = 3'h3; // Shift bits 33:32, write triggers
  localparam logic [2:0] REG_BUF = 3'h4;   // Buffer configuration
  localparam logic [2:0] REG_STAT = 3'h5;  // Status
  localparam int BUF_DIFF = 0;             // 1: differential mode
  localparam int BUF_INV = 1;              // 1: complement pad inverted
  localparam int BUF_SWING = 2;            // Swing code, two bits
  localparam int BUF_IMP = 4;              // Impedance code, two bits
  localparam int BUF_SUP = 6;              // Supply code, three bits
  localparam int BUF_CM = 9;               // Common-mode code, three bits
  localparam int BUF_W = 12;               // Buffer field width
  localparam logic [11:0] BUF_RST = 12'h0_003; // Differential, inverted
  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW = 2'b10
  } phase_t;
endpackage

// File: verilog/output_coarse_phase_adjust.sv
// One output stage: integer divider, coarse phase shift, buffer config
`timescale 1ns/1ps
`default_nettype none
module output_coarse_phase_adjust
  import coarse_phase_pkg::*;
(
  input wire logic clock, // Source divider clock
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic true_pad,
  output logic complement_pad,
  output logic diff_mode,
  output logic [1:0] swing_select,
  output logic [1:0] impedance_select,
  output logic [2:0] pad_supply_select,
  output logic [2:0] common_mode_select
);
  logic [DIV_W-1:0] div_r;             // Integer divide value
  logic [DIV_W-1:0] high_r;            // Pulse high width, zero balanced
  logic [31:0] adj_lo_r;               // Staged low shift bits
  logic signed [ADJ_W-1:0] adj_r;      // Pending shift
  logic pend_r;                        // Shift waiting for boundary
  logic [BUF_W-1:0] buf_r;             // Buffer configuration
  phase_t ph_r;                        // Current half
  logic [CNT_W-1:0] cnt_r;             // Cycles left in half
  logic [CNT_W-1:0] hi_len_r, lo_len_r; // Lengths of period in progress
  logic [CNT_W-1:0] hi_plain, lo_plain, hi_shift, lo_shift;
  logic out_r;                         // Divided clock
  logic [31:0] applied_r;              // Count of shifts applied
  logic boundary;                      // Last cycle of a period

  // Plain split, used when no shift is pending
  shift_split u_plain (
    .div_value(div_r),
    .high_width(high_r),
    .shift('0),
    .high_len(hi_plain),
    .low_len(lo_plain)
  );
  // Shifted split for the one period that takes the request
  shift_split u_shift (
    .div_value(div_r),
    .high_width(high_r),
    .shift(adj_r),
    .high_len(hi_shift),
    .low_len(lo_shift)
  );

  // Register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r <= DIV_RST;
      high_r <= HIGH_RST;
      adj_lo_r <= '0;
      buf_r <= BUF_RST;
    end else if (wr) begin
      unique case (addr)
        REG_DIV: div_r <= wdata;
        REG_HIGH: high_r <= wdata;
        REG_ADJ_LO: adj_lo_r <= wdata;
        REG_BUF: buf_r <= wdata[BUF_W-1:0];
        default: ;
      endcase
    end
  end

  // Pending request; a new write at the boundary wins over the consume
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      adj_r <= '0;
    end else if (wr && addr == REG_ADJ_HI) begin
      pend_r <= 1'b1;
      adj_r <= {wdata[1:0], adj_lo_r};
    end else if (boundary) begin
      pend_r <= 1'b0;
    end
  end

  assign boundary = (ph_r == PH_LOW) && (cnt_r <= CNT_W'(1));

  // Divider state: count out high then low halves
  // Lengths are latched at each boundary, so a register write in mid
  // period never tears the half already being counted out.
  // A shift therefore always waits for the next rising edge.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_r <= PH_HIGH;
      cnt_r <= CNT_W'(1);
      hi_len_r <= CNT_W'(MIN_HALF);
      lo_len_r <= CNT_W'(MIN_HALF);
      out_r <= 1'b0;
      applied_r <= '0;
    end else begin
      unique case (ph_r)
        PH_HIGH: begin
          if (cnt_r <= CNT_W'(1)) begin
            ph_r <= PH_LOW;
            cnt_r <= lo_len_r;
            out_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        PH_LOW: begin
          if (boundary) begin
            ph_r <= PH_HIGH;
            out_r <= 1'b1;
            if (pend_r) begin
              hi_len_r <= hi_shift;
              lo_len_r <= lo_shift;
              cnt_r <= hi_shift;
              applied_r <= applied_r + 32'h0000_0001;
            end else begin
              hi_len_r <= hi_plain;
              lo_len_r <= lo_plain;
              cnt_r <= hi_plain;
            end
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        REG_DIV: rdata <= div_r;
        REG_HIGH: rdata <= high_r;
        REG_ADJ_LO: rdata <= adj_lo_r;
        REG_ADJ_HI: rdata <= {30'h0000_0000, adj_r[ADJ_W-1:32]};
        REG_BUF: rdata <= {20'h0_0000, buf_r};
        REG_STAT: rdata <= {applied_r[29:0], out_r, pend_r};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // Pads; both carry the clock, complement optionally inverted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      true_pad <= 1'b0;
      complement_pad <= 1'b0;
    end else begin
      true_pad <= out_r;
      complement_pad <= (buf_r[BUF_DIFF] | buf_r[BUF_INV]) ? ~out_r : out_r;
    end
  end

  assign diff_mode = buf_r[BUF_DIFF];
  assign swing_select = buf_r[BUF_SWING +: 2];
  assign impedance_select = buf_r[BUF_IMP +: 2];
  assign pad_supply_select = buf_r[BUF_SUP +: 3];
  assign common_mode_select = buf_r[BUF_CM +: 3];
  // this module is placed once per output stage

  // Halves never below the least length
  min_half_a: assert property (@(posedge clock) disable iff (rst)
    boundary |=> (hi_len_r >= CNT_W'(MIN_HALF)) && (lo_len_r >= CNT_W'(MIN_HALF)))
    else $error("half shorter than two cycles");
  // Pending shift is consumed at the boundary
  consume_a: assert property (@(posedge clock) disable iff (rst)
    (boundary && pend_r && !(wr && addr == REG_ADJ_HI)) |=> !pend_r)
    else $error("shift not consumed");
  // Pulse mode leaves high width unchanged
  pulse_high_a: assert property (@(posedge clock) disable iff (rst)
    (boundary && high_r != '0 && high_r >= MIN_HALF) |=> hi_len_r == CNT_W'(high_r))
    else $error("high width changed in pulse mode");
  // Plain period equals the divide value
  plain_period_a: assert property (@(posedge clock) disable iff (rst)
    (boundary && !pend_r && high_r == '0 && div_r >= 32'h0000_0004)
    |=> hi_len_r + lo_len_r == CNT_W'(div_r))
    else $error("period differs from divide value");
  // Rising edge leaves the low half
  edge_a: assert property (@(posedge clock) disable iff (rst)
    boundary |=> out_r && ph_r == PH_HIGH)
    else $error("no rising edge at boundary");
  // Single-ended pads match when not inverted
  pads_a: assert property (@(posedge clock) disable iff (rst)
    (!buf_r[BUF_DIFF] && !buf_r[BUF_INV]) |=> true_pad == complement_pad)
    else $error("single-ended pads differ");
  // Application count moves once per applied shift
  count_a: assert property (@(posedge clock) disable iff (rst)
    (boundary && pend_r) |=> applied_r == $past(applied_r) + 32'h0000_0001)
    else $error("shift count did not advance");
  // Write of trigger word raises pending
  trigger_a: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == REG_ADJ_HI) |=> pend_r)
    else $error("trigger write not pending");

  // Extra checks on the period engine, the shift path and readback.
  // They sit here rather than in the bench so that every use of the
  // block carries them. Limitation: a shift that pushes a half past the
  // counter width wraps; software keeps requests within the 34-bit range.

  // End of a high half
  sequence high_end_s;
    ph_r == PH_HIGH && cnt_r <= CNT_W'(1);
  endsequence
  // A cycle inside the low half that is not the last one
  sequence low_run_s;
    ph_r == PH_LOW && !boundary;
  endsequence
  // A pending shift meets the period boundary
  sequence shift_taken_s;
    boundary && pend_r;
  endsequence

  // High half hands over to the low half with its latched length
  high_end_a: assert property (@(posedge clock) disable iff (rst)
    high_end_s |=> ph_r == PH_LOW && !out_r && cnt_r == $past(lo_len_r))
    else $error("low half not entered");
  // Low half counts down one source period per cycle
  low_run_a: assert property (@(posedge clock) disable iff (rst)
    low_run_s |=> ph_r == PH_LOW && cnt_r == $past(cnt_r) - CNT_W'(1))
    else $error("low half count wrong");
  // Shifted lengths are the ones latched for the new period
  shift_len_a: assert property (@(posedge clock) disable iff (rst)
    shift_taken_s |=> hi_len_r == $past(hi_shift) && lo_len_r == $past(lo_shift))
    else $error("shifted lengths not taken");
  // Without a request the plain split is used again
  plain_len_a: assert property (@(posedge clock) disable iff (rst)
    (boundary && !pend_r) |=> hi_len_r == $past(hi_plain) && lo_len_r == $past(lo_plain))
    else $error("plain lengths not restored");
  // Balanced duty keeps high and low within two cycles of each other
  balance_split_a: assert property (@(posedge clock) disable iff (rst)
    (boundary && high_r == '0) |=> hi_len_r >= lo_len_r && hi_len_r - lo_len_r <= CNT_W'(2))
    else $error("balanced split uneven");
  // Output is low for the whole low half
  low_level_a: assert property (@(posedge clock) disable iff (rst)
    (ph_r == PH_LOW) |-> !out_r)
    else $error("output high in low half");
  // Counter never idles at zero
  cnt_live_a: assert property (@(posedge clock) disable iff (rst)
    cnt_r != '0)
    else $error("half counter at zero");
  // Phase state stays one-hot
  phase_code_a: assert property (@(posedge clock) disable iff (rst)
    $onehot(ph_r))
    else $error("phase state not one-hot");
  // A request waits until its boundary
  pend_hold_a: assert property (@(posedge clock) disable iff (rst)
    (pend_r && !boundary) |=> pend_r)
    else $error("request lost before boundary");
  // Count only moves when a shift is applied
  count_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(boundary && pend_r) |=> $stable(applied_r))
    else $error("shift count moved without shift");
  // Trigger write keeps the staged low bits
  shift_low_a: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == REG_ADJ_HI) |=> adj_r[31:0] == $past(adj_lo_r))
    else $error("staged low shift bits lost");
  // Differential mode drives complementary pads
  diff_pads_a: assert property (@(posedge clock) disable iff (rst)
    buf_r[BUF_DIFF] |=> complement_pad != true_pad)
    else $error("differential pads not complementary");
  // Inversion option flips the complement pad
  inv_pads_a: assert property (@(posedge clock) disable iff (rst)
    buf_r[BUF_INV] |=> complement_pad != true_pad)
    else $error("complement pad not inverted");
  // Divider value reads back the cycle after the strobe
  read_div_a: assert property (@(posedge clock) disable iff (rst)
    (rd && addr == REG_DIV) |=> rdata == $past(div_r))
    else $error("divider readback wrong");
  // Pulse width reads back the cycle after the strobe
  read_high_a: assert property (@(posedge clock) disable iff (rst)
    (rd && addr == REG_HIGH) |=> rdata == $past(high_r))
    else $error("high width readback wrong");
  // Buffer codes read back the cycle after the strobe
  read_buf_a: assert property (@(posedge clock) disable iff (rst)
    (rd && addr == REG_BUF) |=> rdata[BUF_W-1:0] == $past(buf_r))
    else $error("buffer readback wrong");
  // Read data return to zero when no read is made
  read_idle_a: assert property (@(posedge clock) disable iff (rst)
    !rd |=> rdata == '0)
    else $error("read data not idle");
endmodule // output_coarse_phase_adjust
`default_nettype wire

// File: verilog/shift_split.sv
// Splits a signed shift between high and low halves (pulse mode: all on low) with clamping
`timescale 1ns/1ps
`default_nettype none
module shift_split
  import coarse_phase_pkg::*;
(
  input wire logic [DIV_W-1:0] div_value,
  input wire logic [DIV_W-1:0] high_width,
  input wire logic signed [ADJ_W-1:0] shift,
  output logic [CNT_W-1:0] high_len,
  output logic [CNT_W-1:0] low_len
);
  // Signed arithmetic wide enough for any sum
  logic signed [CNT_W+1:0] base_hi, base_lo, add_hi, add_lo, new_hi, new_lo;

  // Clamp a half to the least length
  function automatic logic [CNT_W-1:0] clamp(input logic signed [CNT_W+1:0] v);
    if (v < $signed({5'h00, MIN_HALF}))
      clamp = CNT_W'(MIN_HALF);
    else
      clamp = v[CNT_W-1:0];
  endfunction

  // Base halves then share of the shift
  always_comb begin
    if (high_width == '0) begin
      base_hi = $signed({5'h00, div_value - (div_value >> 1)});
      base_lo = $signed({5'h00, div_value >> 1});
      add_hi = (CNT_W+2)'(shift >>> 1) + (CNT_W+2)'(shift[0]);
      add_lo = (CNT_W+2)'(shift >>> 1);
    end else begin
      base_hi = $signed({5'h00, high_width});
      base_lo = $signed({5'h00, div_value - high_width});
      add_hi = '0;
      add_lo = (CNT_W+2)'(shift);
    end
    new_hi = base_hi + add_hi;
    new_lo = base_lo + add_lo;
    high_len = clamp(new_hi);
    low_len = clamp(new_lo);
  end
endmodule // shift_split
`default_nettype wire
